// file: rtl/vbi_copy_and_widescreen_inserter.sv
// copy management and wide screen word insertion into luma blanking lines
`timescale 1ns/1ps
`include "vbi_insert_params.svh"
module vbi_copy_and_widescreen_inserter #(
  parameter int BIT_CYCLES = 5,
  parameter int LEAD_CYCLES = 40,
  parameter int RUNIN_LEN = 16,
  parameter logic [15:0] RUNIN_PAT = 16'h5555,
  parameter int START_LEN = 8,
  parameter logic [7:0] START_PAT = 8'h1e,
  parameter logic [9:0] BLACK_LEVEL = 10'h040,
  parameter logic [9:0] HIGH_LEVEL = 10'h200
) (
  input wire logic mclk_i,
  input wire logic reset_i,
  input wire logic reg_wr_i,
  input wire logic [7:0] reg_addr_i,
  input wire logic [7:0] reg_wdata_i,
  output logic [7:0] reg_rdata_o,
  input wire vbi_insert_pkg::video_std_type std_i,
  input wire logic line_start_i,
  input wire logic [10:0] line_i,
  input wire logic field_odd_i,
  input wire logic [9:0] luma_i,
  output logic [9:0] luma_o,
  output logic insert_active_o
);
  import vbi_insert_pkg::*;

  localparam int FRAME_W = 64;
  localparam logic [10:0] WIDE_CYC = 11'(`WIDE_VIDEO_CYC);

  // register file
  logic [7:0] ctrl_q;
  logic [7:0] ctrl_d;
  logic [7:0] blank_q;
  logic [7:0] blank_d;
  logic [7:0] prog_q [3];
  logic [7:0] prog_d [3];
  logic [7:0] sd_q [3];
  logic [7:0] sd_d [3];
  logic [7:0] rdata_d;

  // transmitter state
  tx_state_type st_q;
  tx_state_type st_d;
  logic [10:0] cyc_q;
  logic [10:0] cyc_d;
  logic [FRAME_W-1:0] frame_q;
  logic [FRAME_W-1:0] frame_d;
  logic [5:0] len_q;
  logic [5:0] len_d;
  logic [5:0] bit_q;
  logic [5:0] bit_d;
  logic [7:0] sub_q;
  logic [7:0] sub_d;
  logic wide_q;
  logic wide_d;
  logic prog_kind_q;
  logic prog_kind_d;
  logic [9:0] luma_d;

  // line decode
  logic hit_prog;
  logic hit_sd;
  logic hit_wide;
  logic [19:0] prog_raw;
  logic [19:0] prog_word;
  logic [19:0] sd_raw;
  logic [19:0] sd_word;
  logic [13:0] wide_word;

  function automatic logic [5:0] crc6(input logic [13:0] d);
    logic [5:0] c;
    logic fb;
    c = `CRC_PRESET;
    for (int i = 0; i < `PAYLOAD_BITS; i++) begin
      fb = d[i] ^ c[5];
      c = {c[4:1], c[0] ^ fb, fb};
    end
    return c;
  endfunction

  always_comb begin
    ctrl_d = ctrl_q;
    blank_d = blank_q;
    prog_d = prog_q;
    sd_d = sd_q;
    if (reg_wr_i) begin
      case (reg_addr_i)
        `REG_CTRL: ctrl_d = reg_wdata_i;
        `REG_BLANK: blank_d = reg_wdata_i;
        `REG_PROG_DATA0: prog_d[0] = reg_wdata_i;
        `REG_PROG_DATA1: prog_d[1] = reg_wdata_i;
        `REG_PROG_DATA2: prog_d[2] = reg_wdata_i;
        `REG_SD_DATA0: sd_d[0] = reg_wdata_i;
        `REG_SD_DATA1: sd_d[1] = reg_wdata_i;
        `REG_SD_DATA2: sd_d[2] = reg_wdata_i;
        default: ;
      endcase
    end
    case (reg_addr_i)
      `REG_CTRL: rdata_d = ctrl_q;
      `REG_BLANK: rdata_d = blank_q;
      `REG_PROG_DATA0: rdata_d = prog_q[0];
      `REG_PROG_DATA1: rdata_d = prog_q[1];
      `REG_PROG_DATA2: rdata_d = prog_q[2];
      `REG_SD_DATA0: rdata_d = sd_q[0];
      `REG_SD_DATA1: rdata_d = sd_q[1];
      `REG_SD_DATA2: rdata_d = sd_q[2];
      default: rdata_d = 8'h00;
    endcase
  end

  always_ff @(posedge mclk_i) begin
    if (reset_i) begin
      ctrl_q <= `REG_RESET;
      blank_q <= `REG_RESET;
      prog_q <= '{default: `REG_RESET};
      sd_q <= '{default: `REG_RESET};
      reg_rdata_o <= 8'h00;
    end else begin
      ctrl_q <= ctrl_d;
      blank_q <= blank_d;
      prog_q <= prog_d;
      sd_q <= sd_d;
      reg_rdata_o <= rdata_d;
    end
  end

  // word assembly; data_0 low nibble carries C16..C19
  always_comb begin
    if (std_i == std_625p) begin
      prog_raw = {4'h0, prog_q[1], prog_q[2]};
    end else begin
      prog_raw = {prog_q[0][3:0], prog_q[1], prog_q[2]};
    end
    if (ctrl_q[`CTRL_PROG_CRC]) begin
      prog_word = {crc6(prog_raw[13:0]), prog_raw[13:0]};
    end else begin
      prog_word = prog_raw;
    end
    sd_raw = {sd_q[0][3:0], sd_q[1], sd_q[2]};
    if (sd_q[0][`SD_CRC_EN]) begin
      sd_word = {crc6(sd_raw[13:0]), sd_raw[13:0]};
    end else begin
      sd_word = sd_raw;
    end
    // aspect parity and mode bits are software's job, passed as written
    wide_word = {sd_q[1][5:0], sd_q[2]};
  end

  always_comb begin
    hit_prog = 1'b0;
    if (ctrl_q[`CTRL_PROG_EN]) begin
      case (std_i)
        std_525p: hit_prog = (line_i == `LINE_525P);
        std_625p: hit_prog = (line_i == `LINE_625P);
        std_720p: hit_prog = (line_i == `LINE_720P);
        std_1080i: hit_prog = (line_i == `LINE_1080I_A) || (line_i == `LINE_1080I_B);
        default: hit_prog = 1'b0;
      endcase
    end
    // only NTSC carries the standard definition word
    hit_sd = (std_i == std_ntsc) &&
      ((field_odd_i && sd_q[0][`SD_ODD_SEL] && line_i == `LINE_SD_ODD) ||
      (!field_odd_i && sd_q[0][`SD_EVEN_SEL] && line_i == `LINE_SD_EVEN));
    hit_wide = (std_i == std_pal) && sd_q[0][`SD_WIDE_EN] &&
      (line_i == `LINE_WIDE);
  end

  always_comb begin
    st_d = st_q;
    cyc_d = (cyc_q == 11'h7ff) ? cyc_q : cyc_q + 11'h001;
    frame_d = frame_q;
    len_d = len_q;
    bit_d = bit_q;
    sub_d = sub_q;
    wide_d = wide_q;
    prog_kind_d = prog_kind_q;
    if (line_start_i) begin
      // a new line always aborts whatever was still running
      cyc_d = 11'h000;
      st_d = st_idle;
      wide_d = 1'b0;
      prog_kind_d = 1'b0;
      if (hit_prog) begin
        st_d = st_lead;
        prog_kind_d = 1'b1;
        frame_d = FRAME_W'(prog_word);
        len_d = 6'(`COPY_BITS);
      end else if (hit_sd) begin
        st_d = st_lead;
        frame_d = FRAME_W'({sd_word, 1'b1});
        len_d = 6'(`COPY_BITS + 1);
      end else if (hit_wide) begin
        st_d = st_lead;
        wide_d = 1'b1;
        frame_d = (FRAME_W'(wide_word) << (RUNIN_LEN + START_LEN)) |
          (FRAME_W'(START_PAT) << RUNIN_LEN) | FRAME_W'(RUNIN_PAT);
        len_d = 6'(RUNIN_LEN + START_LEN + `WIDE_BITS);
      end
    end else begin
      case (st_q)
        st_lead: begin
          if (cyc_q == 11'(LEAD_CYCLES - 1)) begin
            st_d = st_send;
            bit_d = 6'h00;
            sub_d = 8'h00;
          end
        end
        st_send: begin
          if (sub_q == 8'(BIT_CYCLES - 1)) begin
            sub_d = 8'h00;
            if (bit_q == len_q - 6'h01) begin
              st_d = st_tail;
            end else begin
              bit_d = bit_q + 6'h01;
            end
          end else begin
            sub_d = sub_q + 8'h01;
          end
        end
        st_tail: begin
          // copy lines stay blank to the line end; line 23 reopens to video
          if (wide_q && cyc_q >= WIDE_CYC - 11'h001) begin
            st_d = st_idle;
          end
        end
        default: st_d = st_idle;
      endcase
    end
  end

  always_comb begin
    case (st_q)
      st_idle: luma_d = luma_i;
      st_send: begin
        if (wide_q && blank_q[`BLANK_WIDE]) begin
          luma_d = BLACK_LEVEL;
        end else begin
          luma_d = frame_q[bit_q] ? HIGH_LEVEL : BLACK_LEVEL;
        end
      end
      default: luma_d = BLACK_LEVEL;
    endcase
  end

  always_ff @(posedge mclk_i) begin
    if (reset_i) begin
      st_q <= st_idle;
      cyc_q <= 11'h000;
      frame_q <= '0;
      len_q <= 6'h00;
      bit_q <= 6'h00;
      sub_q <= 8'h00;
      wide_q <= 1'b0;
      prog_kind_q <= 1'b0;
      luma_o <= 10'h000;
    end else begin
      st_q <= st_d;
      cyc_q <= cyc_d;
      frame_q <= frame_d;
      len_q <= len_d;
      bit_q <= bit_d;
      sub_q <= sub_d;
      wide_q <= wide_d;
      prog_kind_q <= prog_kind_d;
      luma_o <= luma_d;
    end
  end

  assign insert_active_o = (st_q != st_idle);

  a_line_525p_hit: assert property (@(posedge mclk_i) disable iff (reset_i)
    (line_start_i && std_i == std_525p && ctrl_q[`CTRL_PROG_EN] && line_i == `LINE_525P)
    |=> insert_active_o && prog_kind_q)
    else $error("525p copy word not started on its line");

  a_line_625p_hit: assert property (@(posedge mclk_i) disable iff (reset_i)
    (line_start_i && std_i == std_625p && ctrl_q[`CTRL_PROG_EN] && line_i == `LINE_625P)
    |=> insert_active_o && frame_q[19:16] == 4'h0)
    else $error("625p copy word wrong line or payload");

  a_line_720p_hit: assert property (@(posedge mclk_i) disable iff (reset_i)
    (line_start_i && std_i == std_720p && ctrl_q[`CTRL_PROG_EN] && line_i == `LINE_720P)
    |=> insert_active_o)
    else $error("720p copy word not started");

  a_line_1080_hit: assert property (@(posedge mclk_i) disable iff (reset_i)
    (line_start_i && std_i == std_1080i && ctrl_q[`CTRL_PROG_EN]
    && (line_i == `LINE_1080I_A || line_i == `LINE_1080I_B)) |=> insert_active_o)
    else $error("1080i copy word not started");

  a_sd_field_gate: assert property (@(posedge mclk_i) disable iff (reset_i)
    (line_start_i && std_i == std_ntsc && line_i == `LINE_SD_ODD && field_odd_i)
    |=> insert_active_o == $past(sd_q[0][`SD_ODD_SEL]))
    else $error("odd field select not honoured");

  a_sd_pal_quiet: assert property (@(posedge mclk_i) disable iff (reset_i)
    (line_start_i && std_i != std_ntsc
    && (line_i == `LINE_SD_ODD || line_i == `LINE_SD_EVEN)) |=> !insert_active_o)
    else $error("standard definition word outside NTSC");

  a_crc_filled: assert property (@(posedge mclk_i) disable iff (reset_i)
    (line_start_i && hit_prog && ctrl_q[`CTRL_PROG_CRC])
    |=> frame_q[19:14] == crc6(frame_q[13:0]))
    else $error("check bits not computed");

  a_wide_pal_only: assert property (@(posedge mclk_i) disable iff (reset_i)
    (line_start_i && std_i != std_pal) |=> !wide_q)
    else $error("wide screen word outside PAL");

  a_wide_video_back: assert property (@(posedge mclk_i) disable iff (reset_i)
    (insert_active_o && wide_q) |-> cyc_q < WIDE_CYC)
    else $error("line 23 video not resumed in time");

  a_wide_blanked: assert property (@(posedge mclk_i) disable iff (reset_i)
    (st_q == st_send && wide_q && blank_q[`BLANK_WIDE] && !line_start_i)
    |=> luma_o == BLACK_LEVEL)
    else $error("blanked wide screen portion not black");

endmodule // vbi_copy_and_widescreen_inserter

// file: rtl/vbi_insert_params.svh
// constants for the vertical blanking copy and wide screen inserter
// Operation
// - 525p with progressive insertion enabled puts the word on line 41.
// - 525p payload comes from the three registers at 0x21, 0x22, 0x23.
// - 625p with progressive insertion enabled puts the word on line 43.
// - 625p payload comes only from registers 0x22 and 0x23.
// - HD payload comes from 0x21, 0x22 and 0x23.
// - 720p inserts the word on line 24.
// - 1080i inserts the word on lines 19 and 582.
// - standard definition sends on line 20 odd fields, line 283 even.
// - separate odd and even field select bits gate the standard definition word.
// - standard definition word is sent only in NTSC.
// - every copy word is 20 bits, C0 to C19.
// - one reference pulse of one bit cell precedes the standard definition word.
// - with CRC enabled, C14 to C19 are computed from C0 to C13.
// - CRC polynomial x^6 + x + 1, register preset to all ones.
// - with CRC disabled all 20 register bits go out unchanged.
// - wide screen word, enabled by 0x59 bit 7, goes on line 23.
// - wide screen word is sent only in PAL.
// - wide screen word is 14 bits after a run-in and a start code.
// - line 23 returns to video 42.5 us after the sync edge.
// - 0x61 bit 7 blanks the wide screen portion of line 23.
`ifndef VBI_INSERT_PARAMS_SVH
`define VBI_INSERT_PARAMS_SVH
`define REG_CTRL 8'h12
`define REG_PROG_DATA0 8'h21
`define REG_PROG_DATA1 8'h22
`define REG_PROG_DATA2 8'h23
`define REG_SD_DATA0 8'h59
`define REG_SD_DATA1 8'h5a
`define REG_SD_DATA2 8'h5b
`define REG_BLANK 8'h61
`define REG_RESET 8'h00
`define CTRL_PROG_EN 6
`define CTRL_PROG_CRC 7
`define SD_CRC_EN 4
`define SD_ODD_SEL 5
`define SD_EVEN_SEL 6
`define SD_WIDE_EN 7
`define BLANK_WIDE 7
`define LINE_525P 11'h029
`define LINE_625P 11'h02b
`define LINE_720P 11'h018
`define LINE_1080I_A 11'h013
`define LINE_1080I_B 11'h246
`define LINE_SD_ODD 11'h014
`define LINE_SD_EVEN 11'h11b
`define LINE_WIDE 11'h017
`define COPY_BITS 20
`define PAYLOAD_BITS 14
`define WIDE_BITS 14
`define CRC_PRESET 6'h3f
`define CLK_PERIOD_NS 100
`define WIDE_VIDEO_NS 42500
`define WIDE_VIDEO_CYC ((`WIDE_VIDEO_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`endif

// file: rtl/vbi_insert_pkg.sv
// types for the vertical blanking copy and wide screen inserter
package vbi_insert_pkg;
  typedef enum logic [2:0] {
    std_ntsc,
    std_pal,
    std_525p,
    std_625p,
    std_720p,
    std_1080i
  } video_std_type;
  typedef enum logic [1:0] {
    st_idle,
    st_lead,
    st_send,
    st_tail
  } tx_state_type;
endpackage

// file: sim/luma_sink.sv
// behavioural luma receiver that slices inserted bit cells
`timescale 1ns/1ps
module luma_sink #(
  parameter int BIT_CYCLES = 5,
  parameter int LEAD_CYCLES = 40,
  parameter logic [9:0] HIGH_LEVEL = 10'h200
) (
  input wire logic mclk_i,
  input wire logic reset_i,
  input wire logic line_start_i,
  input wire logic [9:0] luma_i,
  output logic [63:0] bits_o
);
  int cnt_q;
  int pos;
  assign pos = cnt_q - LEAD_CYCLES - 2;
  always_ff @(posedge mclk_i) begin
    if (reset_i || line_start_i) begin
      cnt_q <= 1;
      bits_o <= '0;
    end else begin
      cnt_q <= cnt_q + 1;
      // cell centre, so an edge a cycle off still slices right
      if (pos >= 0 && pos < 64 * BIT_CYCLES && pos % BIT_CYCLES == BIT_CYCLES / 2) begin
        bits_o[pos / BIT_CYCLES] <= (luma_i === HIGH_LEVEL);
      end
    end
  end
endmodule // luma_sink

// file: sim/vbi_copy_and_widescreen_inserter_tb.sv
// testbench for the copy and wide screen inserter
`timescale 1ns/1ps
`include "vbi_insert_params.svh"
module vbi_copy_and_widescreen_inserter_tb;
  import vbi_insert_pkg::*;
  logic mclk_i = 0;
  logic reset_i = 1;
  logic reg_wr_i = 0;
  logic [7:0] reg_addr_i = '0;
  logic [7:0] reg_wdata_i = '0;
  logic [7:0] reg_rdata_o;
  video_std_type std_i = std_ntsc;
  logic line_start_i = 0;
  logic [10:0] line_i = '0;
  logic field_odd_i = 0;
  logic [9:0] luma_i = 10'h155;
  logic [9:0] luma_o;
  logic insert_active_o;
  logic [63:0] bits;
  logic a1;
  logic a2;
  logic [7:0] rv;
  int miscompares = 0;
  int checks_done = 0;
  always #50 mclk_i = ~mclk_i;
  vbi_copy_and_widescreen_inserter DUT (.mclk_i(mclk_i), .reset_i(reset_i),
    .reg_wr_i(reg_wr_i), .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i),
    .reg_rdata_o(reg_rdata_o), .std_i(std_i), .line_start_i(line_start_i),
    .line_i(line_i), .field_odd_i(field_odd_i), .luma_i(luma_i), .luma_o(luma_o),
    .insert_active_o(insert_active_o));
  luma_sink SINK (.mclk_i(mclk_i), .reset_i(reset_i), .line_start_i(line_start_i),
    .luma_i(luma_o), .bits_o(bits));
  task automatic final_report();
    if (miscompares == 0 && checks_done > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask
  task automatic chk(input logic [63:0] got, input logic [63:0] exp);
    checks_done++;
    if (got !== exp) begin
      miscompares++;
      $display("BAD %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge mclk_i);
    reg_wr_i = 1;
    reg_addr_i = a;
    reg_wdata_i = d;
    @(negedge mclk_i);
    reg_wr_i = 0;
  endtask
  task automatic rd(input logic [7:0] a);
    @(negedge mclk_i);
    reg_addr_i = a;
    repeat (2) @(negedge mclk_i);
    rv = reg_rdata_o;
  endtask
  // a1 just after the start, a2 late in the line, bits once it is over
  task automatic run_line(input video_std_type s, input logic [10:0] n, input logic odd);
    @(negedge mclk_i);
    std_i = s;
    line_i = n;
    field_odd_i = odd;
    line_start_i = 1;
    @(negedge mclk_i);
    line_start_i = 0;
    repeat (2) @(negedge mclk_i);
    a1 = insert_active_o;
    repeat (418) @(negedge mclk_i);
    a2 = insert_active_o;
    repeat (20) @(negedge mclk_i);
  endtask
  function automatic logic [19:0] with_crc(input logic [13:0] d);
    logic [5:0] c;
    logic fb;
    c = 6'h3f;
    for (int i = 0; i < 14; i++) begin
      fb = d[i] ^ c[5];
      c = {c[4:1], c[0] ^ fb, fb};
    end
    return {c, d};
  endfunction
  task automatic t_regs();
    rd(`REG_CTRL);
    chk(rv, 8'h00);
    wr(`REG_PROG_DATA0, 8'ha5);
    rd(`REG_PROG_DATA0);
    chk(rv, 8'ha5);
    wr(8'h30, 8'h5a);
    rd(8'h30);
    chk(rv, 8'h00);
  endtask
  task automatic t_prog();
    wr(`REG_CTRL, 8'h40);
    wr(`REG_PROG_DATA0, 8'h0a);
    wr(`REG_PROG_DATA1, 8'h34);
    wr(`REG_PROG_DATA2, 8'h56);
    run_line(std_525p, `LINE_525P, 1);
    chk(a1, 1);
    chk(bits, 64'h0000_0000_000a_3456);
    chk(a2, 1);
    run_line(std_525p, `LINE_625P, 1);
    chk(a1, 0);
    run_line(std_625p, `LINE_625P, 1);
    chk(a1, 1);
    chk(bits, 64'h0000_0000_0000_3456);
    run_line(std_1080i, `LINE_1080I_B, 0);
    chk(bits, 64'h0000_0000_000a_3456);
    wr(`REG_CTRL, 8'h00);
    run_line(std_525p, `LINE_525P, 1);
    chk(a1, 0);
  endtask
  task automatic t_hd();
    wr(`REG_CTRL, 8'hc0);
    run_line(std_720p, `LINE_720P, 1);
    chk(a1, 1);
    chk(bits, {44'h0, with_crc(14'h3456)});
    run_line(std_1080i, `LINE_1080I_A, 1);
    chk(bits, {44'h0, with_crc(14'h3456)});
    run_line(std_720p, `LINE_1080I_A, 1);
    chk(a1, 0);
  endtask
  task automatic t_sd();
    wr(`REG_SD_DATA0, 8'h30);
    wr(`REG_SD_DATA1, 8'h12);
    wr(`REG_SD_DATA2, 8'h34);
    run_line(std_ntsc, `LINE_SD_ODD, 1);
    chk(a1, 1);
    chk(bits, {43'h0, with_crc(14'h1234), 1'b1});
    run_line(std_ntsc, `LINE_SD_EVEN, 0);
    chk(a1, 0);
    wr(`REG_SD_DATA0, 8'h4b);
    run_line(std_ntsc, `LINE_SD_EVEN, 0);
    chk(bits, {43'h0, 20'hb_1234, 1'b1});
    run_line(std_ntsc, `LINE_SD_ODD, 1);
    chk(a1, 0);
    run_line(std_pal, `LINE_SD_EVEN, 0);
    chk(a1, 0);
  endtask
  task automatic t_wide();
    wr(`REG_SD_DATA0, 8'h80);
    wr(`REG_SD_DATA1, 8'h00);
    wr(`REG_SD_DATA2, 8'h18);
    run_line(std_pal, `LINE_WIDE, 1);
    chk(a1, 1);
    chk(bits, 64'h0000_0000_181e_5555);
    chk(a2, 1);
    chk(insert_active_o, 0);
    chk(luma_o, luma_i);
    wr(`REG_BLANK, 8'h80);
    run_line(std_pal, `LINE_WIDE, 1);
    chk(bits, 64'h0000_0000_0000_0000);
    run_line(std_ntsc, `LINE_WIDE, 1);
    chk(a1, 0);
    wr(`REG_SD_DATA0, 8'h00);
    run_line(std_pal, `LINE_WIDE, 1);
    chk(a1, 0);
  endtask
  // whole run is some seven and a half thousand cycles
  initial begin
    #3000000;
    miscompares++;
    final_report();
  end
  initial begin
    repeat (4) @(negedge mclk_i);
    chk(luma_o, 10'h000);
    chk(insert_active_o, 0);
    chk(reg_rdata_o, 8'h00);
    reset_i = 0;
    t_regs();
    t_prog();
    t_hd();
    t_sd();
    t_wide();
    final_report();
  end
endmodule // vbi_copy_and_widescreen_inserter_tb
